// ---- logic/timing_frame_dma_message_formatter.sv ----
// Timing frame to DMA message formatter
`timescale 1ns/1ps

`include "timing_frame_dma_message_formatter_defs.svh"

module timing_frame_dma_message_formatter #(
	parameter int NCH = 12,
	parameter int TIME_ZERO_TICKS = `TIME_ZERO_TICKS,
	parameter int LEGACY_ACQ_BUFFERS = `LEGACY_ACQ_BUFFERS
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	input wire logic frameStrobe,
	input wire logic [63:0] framePulseId,
	input wire logic [31:0] frameNanosec,
	input wire logic [31:0] frameSeconds,
	input wire logic [5:0] frameAcRates,
	input wire logic [6:0] frameFixedRates,
	input wire logic frameResync,
	input wire logic [11:0] frameSlotClocks,
	input wire logic [2:0] frameSlot,
	input wire logic [15:0] frameCharge,
	input wire logic [3:0] frameDest,
	input wire logic frameBeam,
	input wire logic [63:0] frameEnergy,
	input wire logic [31:0] frameWavelen,
	input wire logic [15:0] frameStatus,
	input wire logic [15:0] frameProtLimit,
	input wire logic [63:0] frameProtClass,
	input wire logic [287:0] frameSequences,
	input wire logic frameAcqGlobal,
	input wire logic [63:0] frameInitMask,
	input wire logic [63:0] frameMinorMask,
	input wire logic [63:0] frameMajorMask,
	input wire logic [NCH-1:0] frameAcqChannels,
	input wire logic [63:0] frameActiveMask,
	input wire logic [63:0] frameAverageCompleteMask,
	input wire logic [63:0] frameUpdateMask,
	input wire logic legacyCodeValid,
	input wire logic [7:0] legacyCode,
	input wire logic legacyTick,
	input wire logic dmaReady,
	output logic dmaValid,
	output logic [31:0] dmaData,
	output logic dmaLast,
	output logic triggerOut
);

	timing_frame_dma_message_formatter_pkg::state_type state;
	timing_frame_dma_message_formatter_pkg::state_type nextAfter;
	timing_frame_dma_message_formatter_pkg::state_type firstState;
	timing_frame_dma_message_formatter_pkg::frame_type frameIn;
	timing_frame_dma_message_formatter_pkg::frame_type f;

	logic [31:0] control;
	logic [NCH-1:0] chanEnable;
	logic [31:0] select;
	logic [15:0] dropCount;
	logic [NCH-1:0] lAcqChannels;
	logic lLegacy;
	logic [255:0] codeVec;
	logic [13:0] tickCnt;
	logic [NCH-1:0] pend;
	logic [4:0] idx;
	logic dropPend;
	logic [31:0] curWord;
	logic [3:0] curCh;
	logic [NCH-1:0] curChOh;

	// Register decode
	wire legacyMode = control[`CTRL_LEGACY_BIT];
	wire trigEnable = control[`CTRL_TRIGGER_BIT];
	wire dmaEnable = control[`CTRL_DMA_BIT];
	wire [1:0] selMode = control[`CTRL_SELMODE_MSB:`CTRL_SELMODE_LSB];
	wire [5:0] selRates = select[`SEL_RATE_MSB:`SEL_RATE_LSB];
	wire [5:0] selSlots = select[`SEL_SLOT_MSB:`SEL_SLOT_LSB];
	wire [7:0] selCode = select[`SEL_CODE_MSB:`SEL_CODE_LSB];
	wire hitControl = regAddr == `REG_CONTROL;
	wire hitChan = regAddr == `REG_CHAN_ENABLE;
	wire hitSelect = regAddr == `REG_SELECT;
	wire hitStatus = regAddr == `REG_STATUS;
	wire hitDrop = regAddr == `REG_DROP_COUNT;
	wire busy = state != timing_frame_dma_message_formatter_pkg::S_IDLE;
	wire [31:0] statusWord = {24'h0000_00, state, dropPend, busy};
	wire [31:0] readMux = hitControl ? control :
		hitChan ? {{(32 - NCH){1'b0}}, chanEnable} :
		hitSelect ? select :
		hitStatus ? statusWord :
		hitDrop ? {16'h0000, dropCount} : 32'h0000_0000;

	// Frame capture; a strobe while busy is dropped and remembered
	wire accept = frameStrobe && !busy;
	wire dropNow = frameStrobe && busy;
	assign frameIn = {framePulseId, frameNanosec, frameSeconds, frameAcRates, frameFixedRates,
		frameResync, frameSlotClocks, frameSlot, frameCharge, frameDest, frameBeam, frameEnergy,
		frameWavelen, frameStatus, frameProtLimit, frameProtClass, frameSequences, frameAcqGlobal,
		frameInitMask, frameMinorMask, frameMajorMask, frameActiveMask, frameAverageCompleteMask,
		frameUpdateMask};

	// Legacy acquisition buffers limited to the low buffer numbers
	wire [63:0] bufMask = lLegacy ? ((64'h0000_0000_0000_0001 << LEGACY_ACQ_BUFFERS) -
		64'h0000_0000_0000_0001) : 64'hFFFF_FFFF_FFFF_FFFF;
	wire [63:0] initMask = f.initMask & bufMask;
	wire [63:0] minorMask = f.minorMask & bufMask;
	wire [63:0] majorMask = f.majorMask & bufMask;
	wire [63:0] activeMask = f.activeMask & bufMask;
	wire [63:0] avgMask = f.avgDoneMask & bufMask;
	wire [63:0] updateMask = f.updateMask & bufMask;

	// Legacy event selector
	wire [7:0] slotOh = 8'h01 << f.slot;
	wire acHit = |(selRates & f.acRates) && |(selSlots & slotOh[6:1]);
	wire selHit = (selMode == `SELMODE_AC) ? acHit :
		(selMode == `SELMODE_SEQ) ? codeVec[selCode] : 1'b0;
	wire selected = lLegacy ? selHit : |chanEnable;
	wire tickCap = tickCnt == 14'h3FFF;
	wire zeroReached = tickCnt >= 14'(TIME_ZERO_TICKS);
	wire waitDone = !lLegacy || zeroReached;

	// Message plan for one strobe
	wire sendEvent = dmaEnable && selected;
	wire sendGlobal = dmaEnable && f.acqGlobal;
	wire [NCH-1:0] pendStart = lAcqChannels & chanEnable & {NCH{dmaEnable}};
	wire [NCH-1:0] pendAfter = pend & ~curChOh;
	wire anyMsg = sendEvent || sendGlobal || |pendStart;
	assign firstState = sendEvent ? timing_frame_dma_message_formatter_pkg::S_EVENT :
		sendGlobal ? timing_frame_dma_message_formatter_pkg::S_GLOBAL :
		|pendStart ? timing_frame_dma_message_formatter_pkg::S_PULSE :
		timing_frame_dma_message_formatter_pkg::S_IDLE;

	// Output word handshake
	wire take = !dmaValid || dmaReady;
	wire inMsg = state inside {timing_frame_dma_message_formatter_pkg::S_EVENT,
		timing_frame_dma_message_formatter_pkg::S_GLOBAL,
		timing_frame_dma_message_formatter_pkg::S_PULSE,
		timing_frame_dma_message_formatter_pkg::S_END};
	wire [4:0] lastIdx = (state == timing_frame_dma_message_formatter_pkg::S_EVENT) ?
		`EVENT_WORDS - 5'd1 : (state == timing_frame_dma_message_formatter_pkg::S_END) ?
		5'd0 : `ACQ_GLOBAL_WORDS - 5'd1;
	wire msgDone = take && inMsg && idx == lastIdx;
	wire headerOut = take && inMsg && idx == 5'd0;

	// Header fields
	wire [7:0] ownByte = {1'b1, dropPend, 6'b00_0000};
	wire [1:0] tagFlags = {dropPend, lLegacy};
	wire [15:0] maskField = {{(16 - NCH){1'b0}}, chanEnable};
	wire [287:0] seqField = lLegacy ? {32'h0000_0000, codeVec} : f.sequences;
	wire [15:0] rateField = {f.acRates, 3'b000, f.fixedRates};
	wire [15:0] slotField = {f.resync, f.slotClocks, f.slot};

	// Lowest pending channel for pulse messages
	always_comb begin
		curCh = 4'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pend[i]) begin
				curCh = 4'(i);
			end
		end
	end
	assign curChOh = NCH'(1) << curCh;

	// Next message in the group, original order kept
	// Only a finished pulse message retires its channel
	wire morePulse = (state == timing_frame_dma_message_formatter_pkg::S_PULSE) ? |pendAfter :
		|pend;
	assign nextAfter = (state == timing_frame_dma_message_formatter_pkg::S_EVENT && sendGlobal) ?
		timing_frame_dma_message_formatter_pkg::S_GLOBAL :
		(state != timing_frame_dma_message_formatter_pkg::S_END && morePulse) ?
		timing_frame_dma_message_formatter_pkg::S_PULSE :
		(state == timing_frame_dma_message_formatter_pkg::S_END) ?
		timing_frame_dma_message_formatter_pkg::S_IDLE :
		timing_frame_dma_message_formatter_pkg::S_END;

	// Message word selection, little-endian bytes in each word
	always_comb begin
		curWord = 32'h0000_0000;
		case (state)
			timing_frame_dma_message_formatter_pkg::S_EVENT: begin
				case (idx)
					5'd0: curWord = {ownByte, tagFlags, 2'b00, `TYPE_EVENT, maskField};
					5'd1: curWord = {27'h000_0000, `EVENT_WORDS - `HEADER_WORDS};
					5'd2: curWord = f.pulse_identifier[31:0];
					5'd3: curWord = f.pulse_identifier[63:32];
					5'd4: curWord = f.nanosec;
					5'd5: curWord = f.seconds;
					5'd6: curWord = {slotField, rateField};
					5'd7: curWord = {f.charge, 8'h00, f.dest, 3'b000, f.beam};
					5'd8: curWord = f.energy[31:0];
					5'd9: curWord = f.energy[63:32];
					5'd10: curWord = f.wavelen;
					5'd11: curWord = {f.protLimit, f.status};
					5'd12: curWord = f.protClass[31:0];
					5'd13: curWord = f.protClass[63:32];
					default: curWord = seqField[32 * (idx - 5'd14) +: 32];
				endcase
			end
			timing_frame_dma_message_formatter_pkg::S_GLOBAL: begin
				case (idx)
					5'd0: curWord = {ownByte, tagFlags, 2'b00, `TYPE_ACQ_GLOBAL, maskField};
					5'd1: curWord = f.pulse_identifier[31:0];
					5'd2: curWord = f.pulse_identifier[63:32];
					5'd3: curWord = f.nanosec;
					5'd4: curWord = f.seconds;
					5'd5: curWord = initMask[31:0];
					5'd6: curWord = initMask[63:32];
					5'd7: curWord = minorMask[31:0];
					5'd8: curWord = minorMask[63:32];
					5'd9: curWord = majorMask[31:0];
					5'd10: curWord = majorMask[63:32];
					default: curWord = 32'h0000_0000;
				endcase
			end
			timing_frame_dma_message_formatter_pkg::S_PULSE: begin
				case (idx)
					5'd0: curWord = {ownByte, tagFlags, 2'b00, `TYPE_ACQ_PULSE, 12'h000, curCh};
					5'd1: curWord = f.pulse_identifier[31:0];
					5'd2: curWord = f.pulse_identifier[63:32];
					5'd3: curWord = activeMask[31:0];
					5'd4: curWord = activeMask[63:32];
					5'd5: curWord = avgMask[31:0];
					5'd6: curWord = avgMask[63:32];
					5'd7: curWord = f.nanosec;
					5'd8: curWord = f.seconds;
					5'd9: curWord = updateMask[31:0];
					5'd10: curWord = updateMask[63:32];
					default: curWord = 32'h0000_0000;
				endcase
			end
			timing_frame_dma_message_formatter_pkg::S_END: begin
				curWord = {ownByte, tagFlags, 2'b00, `TYPE_END, maskField};
			end
			default: curWord = 32'h0000_0000;
		endcase
	end

	// Register file
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			control <= `CONTROL_RESET;
			chanEnable <= `CHAN_ENABLE_RESET;
			select <= `SELECT_RESET;
			regRdata <= 32'h0000_0000;
		end else begin
			if (regWrite && hitControl) begin
				control <= regWdata;
			end
			if (regWrite && hitChan) begin
				chanEnable <= regWdata[NCH-1:0];
			end
			if (regWrite && hitSelect) begin
				select <= regWdata;
			end
			regRdata <= regRead ? readMux : 32'h0000_0000;
		end
	end

	// Frame latch
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			f <= '0;
			lAcqChannels <= '0;
			lLegacy <= 1'b0;
		end else if (accept) begin
			f <= frameIn;
			lAcqChannels <= frameAcqChannels;
			lLegacy <= legacyMode;
		end
	end

	// Legacy event codes of the current fiducial; a code in the strobe cycle is kept
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			codeVec <= '0;
		end else begin
			codeVec <= ((accept ? 256'h0 : codeVec) |
				(legacyCodeValid ? (256'h1 << legacyCode) : 256'h0));
		end
	end

	// Ticks since the fiducial
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			tickCnt <= 14'h0000;
		end else if (accept) begin
			tickCnt <= 14'h0000;
		end else if (legacyTick && !tickCap) begin
			tickCnt <= tickCnt + 14'h0001;
		end
	end

	// Drop flag: a new drop wins over the clear by a header
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dropPend <= 1'b0;
			dropCount <= 16'h0000;
		end else begin
			dropPend <= dropNow || (dropPend && !headerOut);
			if (dropNow && dropCount != 16'hFFFF) begin
				dropCount <= dropCount + 16'h0001;
			end
		end
	end

	// Trigger pulse at time zero
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			triggerOut <= 1'b0;
		end else begin
			triggerOut <= state == timing_frame_dma_message_formatter_pkg::S_WAIT && waitDone &&
				trigEnable && selected;
		end
	end

	// Sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state <= timing_frame_dma_message_formatter_pkg::S_IDLE;
			idx <= 5'd0;
			pend <= '0;
		end else begin
			case (state)
				timing_frame_dma_message_formatter_pkg::S_IDLE: begin
					if (accept) begin
						state <= timing_frame_dma_message_formatter_pkg::S_WAIT;
					end
				end
				timing_frame_dma_message_formatter_pkg::S_WAIT: begin
					if (waitDone) begin
						state <= anyMsg ? firstState :
							timing_frame_dma_message_formatter_pkg::S_IDLE;
						pend <= pendStart;
						idx <= 5'd0;
					end
				end
				default: begin
					if (msgDone) begin
						state <= nextAfter;
						idx <= 5'd0;
						if (state == timing_frame_dma_message_formatter_pkg::S_PULSE) begin
							pend <= pendAfter;
						end
					end else if (take) begin
						idx <= idx + 5'd1;
					end
				end
			endcase
		end
	end

	// DMA word output
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dmaValid <= 1'b0;
			dmaData <= 32'h0000_0000;
			dmaLast <= 1'b0;
		end else if (take) begin
			dmaValid <= inMsg;
			dmaData <= inMsg ? curWord : 32'h0000_0000;
			dmaLast <= state == timing_frame_dma_message_formatter_pkg::S_END;
		end
	end

endmodule // timing_frame_dma_message_formatter

// ---- logic/timing_frame_dma_message_formatter_defs.svh ----
// Offsets, field positions, codes and counts of the timing message formatter
`ifndef TIMING_FRAME_DMA_MESSAGE_FORMATTER_DEFS_SVH
`define TIMING_FRAME_DMA_MESSAGE_FORMATTER_DEFS_SVH

// Register byte addresses
`define REG_CONTROL 8'h00
`define REG_CHAN_ENABLE 8'h04
`define REG_SELECT 8'h08
`define REG_STATUS 8'h0C
`define REG_DROP_COUNT 8'h10

// Control register fields
`define CTRL_LEGACY_BIT 0
`define CTRL_TRIGGER_BIT 1
`define CTRL_DMA_BIT 2
`define CTRL_SELMODE_LSB 4
`define CTRL_SELMODE_MSB 5

// Select register fields
`define SEL_RATE_LSB 0
`define SEL_RATE_MSB 5
`define SEL_SLOT_LSB 8
`define SEL_SLOT_MSB 13
`define SEL_CODE_LSB 16
`define SEL_CODE_MSB 23

// Event selector modes
`define SELMODE_FIXED 2'h0
`define SELMODE_AC 2'h1
`define SELMODE_SEQ 2'h2

// Message type codes, header byte 2 bits 3:0
`define TYPE_EVENT 4'h0
`define TYPE_ACQ_GLOBAL 4'h1
`define TYPE_ACQ_PULSE 4'h2
`define TYPE_END 4'hF

// Message lengths in 32-bit words, header included
`define EVENT_WORDS 5'd23
`define ACQ_GLOBAL_WORDS 5'd11
`define ACQ_PULSE_WORDS 5'd11
`define HEADER_WORDS 5'd2
`define MAX_MESSAGE_BYTES 128

// Legacy time zero point, in link ticks after the fiducial
`define TIME_ZERO_TICKS 12116
`define LEGACY_ACQ_BUFFERS 32

// Reset values
`define CONTROL_RESET 32'h0000_0000
`define CHAN_ENABLE_RESET 12'h000
`define SELECT_RESET 32'h0000_0000

`endif

// ---- logic/timing_frame_dma_message_formatter_pkg.sv ----
// Types of the timing message formatter
package timing_frame_dma_message_formatter_pkg;

	typedef enum logic [5:0] {
		S_IDLE = 6'b00_0001,
		S_WAIT = 6'b00_0010,
		S_EVENT = 6'b00_0100,
		S_GLOBAL = 6'b00_1000,
		S_PULSE = 6'b01_0000,
		S_END = 6'b10_0000
	} state_type;

	typedef struct packed {
		logic [63:0] pulse_identifier;
		logic [31:0] nanosec;
		logic [31:0] seconds;
		logic [5:0] acRates;
		logic [6:0] fixedRates;
		logic resync;
		logic [11:0] slotClocks;
		logic [2:0] slot;
		logic [15:0] charge;
		logic [3:0] dest;
		logic beam;
		logic [63:0] energy;
		logic [31:0] wavelen;
		logic [15:0] status;
		logic [15:0] protLimit;
		logic [63:0] protClass;
		logic [287:0] sequences;
		logic acqGlobal;
		logic [63:0] initMask;
		logic [63:0] minorMask;
		logic [63:0] majorMask;
		logic [63:0] activeMask;
		logic [63:0] avgDoneMask;
		logic [63:0] updateMask;
	} frame_type;

endpackage

// ---- sim/dma_host_sink.sv ----
// Host memory model taking DMA words, with optional stalling
`timescale 1ns/1ps

module dma_host_sink (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic stall,
	input wire logic clear,
	input wire logic dmaValid,
	input wire logic [31:0] dmaData,
	output logic dmaReady
);
	logic [31:0] mem [0:255];
	int count;

	// Stalling toggles ready so words must be held
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			dmaReady <= 1'b0;
			count <= 0;
		end else begin
			dmaReady <= stall ? ~dmaReady : 1'b1;
			if (clear)
				count <= 0;
			else if (dmaValid && dmaReady) begin
				mem[count[7:0]] <= dmaData;
				count <= count + 1;
			end
		end
	end
endmodule // dma_host_sink

// ---- sim/test_timing_frame_dma_message_formatter.sv ----
// Testbench of the timing message formatter
`timescale 1ns/1ps
`include "timing_frame_dma_message_formatter_defs.svh"

module test_timing_frame_dma_message_formatter;
	localparam int ZERO_TICKS = 20;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [11:0] chEn;
		logic glob;
		logic [11:0] acq;
		logic stall;
		logic trig;
		logic [7:0] words;
	} row_type;
	row_type rows [0:4] = '{
		'{8'h06, 12'h003, 1'b0, 12'h000, 1'b0, 1'b1, 8'd24},
		'{8'h04, 12'h005, 1'b1, 12'h005, 1'b1, 1'b0, 8'd57},
		'{8'h02, 12'h001, 1'b1, 12'h001, 1'b0, 1'b1, 8'd0},
		'{8'h04, 12'h000, 1'b1, 12'h0F0, 1'b1, 1'b0, 8'd12},
		'{8'h06, 12'h800, 1'b0, 12'h800, 1'b0, 1'b1, 8'd35}};
	logic core_clk, rstn, regWrite, regRead, frameStrobe, frameResync, frameBeam, frameAcqGlobal;
	logic legacyCodeValid, legacyTick, dmaReady, dmaValid, dmaLast, triggerOut, stall, clear;
	logic [7:0] regAddr, legacyCode;
	logic [31:0] regWdata, regRdata, frameNanosec, frameSeconds, frameWavelen, dmaData;
	logic [63:0] framePulseId, frameEnergy, frameProtClass, frameInitMask, frameMinorMask;
	logic [63:0] frameMajorMask, frameActiveMask, frameAverageCompleteMask, frameUpdateMask;
	logic [5:0] frameAcRates;
	logic [6:0] frameFixedRates;
	logic [11:0] frameSlotClocks, frameAcqChannels;
	logic [2:0] frameSlot;
	logic [15:0] frameCharge, frameStatus, frameProtLimit;
	logic [3:0] frameDest;
	logic [287:0] frameSequences;
	logic [31:0] expQ [$];
	logic dropExp;
	int errTotal, testsRun, trigCnt, trigBase, cycles;

	timing_frame_dma_message_formatter #(.TIME_ZERO_TICKS(ZERO_TICKS))
		timing_frame_dma_message_formatter_inst (
		.core_clk, .rstn, .regAddr, .regWdata, .regWrite, .regRead, .regRdata, .frameStrobe,
		.framePulseId, .frameNanosec, .frameSeconds, .frameAcRates, .frameFixedRates, .frameResync,
		.frameSlotClocks, .frameSlot, .frameCharge, .frameDest, .frameBeam, .frameEnergy,
		.frameWavelen, .frameStatus, .frameProtLimit, .frameProtClass, .frameSequences,
		.frameAcqGlobal, .frameInitMask, .frameMinorMask, .frameMajorMask, .frameAcqChannels,
		.frameActiveMask, .frameAverageCompleteMask, .frameUpdateMask, .legacyCodeValid,
		.legacyCode, .legacyTick, .dmaReady, .dmaValid, .dmaData, .dmaLast, .triggerOut);
	dma_host_sink dma_host_sink_inst (.core_clk, .rstn, .stall, .clear, .dmaValid, .dmaData,
		.dmaReady);

	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		trigCnt <= trigCnt + (triggerOut === 1'b1);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errTotal++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			errTotal++;
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge core_clk);
		regWrite <= 1'b0;
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge core_clk);
		regRead <= 1'b0;
		#1 check("register read", exp, regRdata);
	endtask

	task automatic add_msg(input logic [3:0] typ, input logic [15:0] m, input logic lg);
		logic [287:0] sq;
		logic [191:0] ms;
		sq = lg ? (288'h1 << 40) : frameSequences;
		ms = (typ == 4'h1) ? {frameMajorMask, frameMinorMask, frameInitMask} :
			{64'h0, frameAverageCompleteMask, frameActiveMask};
		if (lg)
			ms = ms & {3{32'h0000_0000, 32'hFFFF_FFFF}};
		expQ.push_back({1'b1, dropExp, 6'h00, dropExp, lg, 2'b00, typ, m});
		dropExp = 1'b0;
		if (typ == 4'h0) begin
			expQ.push_back(32'd21);
			expQ.push_back(framePulseId[31:0]);
			expQ.push_back(framePulseId[63:32]);
			expQ.push_back(frameNanosec);
			expQ.push_back(frameSeconds);
			expQ.push_back({frameResync, frameSlotClocks, frameSlot, frameAcRates, 3'b000,
				frameFixedRates});
			expQ.push_back({frameCharge, 8'h00, frameDest, 3'b000, frameBeam});
			expQ.push_back(frameEnergy[31:0]);
			expQ.push_back(frameEnergy[63:32]);
			expQ.push_back(frameWavelen);
			expQ.push_back({frameProtLimit, frameStatus});
			expQ.push_back(frameProtClass[31:0]);
			expQ.push_back(frameProtClass[63:32]);
			for (int i = 0; i < 9; i++)
				expQ.push_back(sq[i*32+:32]);
		end else if (typ != 4'hF) begin
			expQ.push_back(framePulseId[31:0]);
			expQ.push_back(framePulseId[63:32]);
			if (typ == 4'h1) begin
				expQ.push_back(frameNanosec);
				expQ.push_back(frameSeconds);
			end
			for (int i = 0; i < 6; i++)
				expQ.push_back(ms[i*32+:32]);
			if (typ == 4'h2) begin
				for (int i = 0; i < 4; i++)
					expQ.pop_back();
				expQ.push_back(frameAverageCompleteMask[31:0]);
				expQ.push_back(frameAverageCompleteMask[63:32]);
				expQ.push_back(frameNanosec);
				expQ.push_back(frameSeconds);
				expQ.push_back(frameUpdateMask[31:0]);
				expQ.push_back(frameUpdateMask[63:32]);
			end
		end
	endtask

	task automatic run_frame(input logic [7:0] ctrl, input logic [11:0] chEn, input logic glob,
			input logic [11:0] acq, input logic stl, input logic sel, input int strobes);
		reg_wr(`REG_CONTROL, {24'h0, ctrl});
		reg_wr(`REG_CHAN_ENABLE, {20'h0, chEn});
		expQ.delete();
		if (ctrl[2] && sel)
			add_msg(4'h0, {4'h0, chEn}, ctrl[0]);
		if (ctrl[2] && glob)
			add_msg(4'h1, {4'h0, chEn}, ctrl[0]);
		for (int c = 0; c < 12; c++)
			if (ctrl[2] && acq[c] && chEn[c])
				add_msg(4'h2, 16'(c), ctrl[0]);
		if (expQ.size() > 0)
			add_msg(4'hF, {4'h0, chEn}, ctrl[0]);
		@(posedge core_clk);
		frameAcqGlobal <= glob;
		frameAcqChannels <= acq;
		stall <= stl;
		clear <= 1'b1;
		frameStrobe <= 1'b1;
		repeat (strobes) @(posedge core_clk);
		frameStrobe <= 1'b0;
		clear <= 1'b0;
		if (ctrl[0]) begin
			legacyCodeValid <= 1'b1;
			@(posedge core_clk);
			legacyCodeValid <= 1'b0;
			for (int t = 0; t < ZERO_TICKS; t++) begin
				if (t == ZERO_TICKS - 1)
					check("early message", 32'h0, {31'h0, dmaValid});
				legacyTick <= 1'b1;
				@(posedge core_clk);
				legacyTick <= 1'b0;
				repeat (3) @(posedge core_clk);
			end
		end
		for (int i = 0; i < 400; i++) begin
			@(posedge core_clk);
			if (dmaValid === 1'b1 && dmaReady === 1'b1 && dmaLast === 1'b1)
				break;
		end
		repeat (2) @(posedge core_clk);
		check("word count", expQ.size(), dma_host_sink_inst.count);
		for (int i = 0; i < expQ.size(); i++)
			check("message word", expQ[i], dma_host_sink_inst.mem[i]);
		$display("frame done, control %h", ctrl);
	endtask

	initial begin
		{regWrite, regRead, frameStrobe, legacyCodeValid, legacyTick, stall, clear} = '0;
		{regAddr, regWdata, errTotal, testsRun, trigCnt, cycles, dropExp} = '0;
		{frameAcqGlobal, frameAcqChannels} = '0;
		legacyCode = 8'h28;
		{framePulseId, frameNanosec, frameSeconds} = 128'h0123_4567_89AB_CDEF_1111_2222_3333_4444;
		{frameAcRates, frameFixedRates, frameResync, frameSlotClocks, frameSlot} = 29'h0B55_5ABB;
		{frameCharge, frameDest, frameBeam} = 21'h1B_DDF3;
		{frameEnergy, frameWavelen} = 96'h1001_2002_3003_4004_5005_6006;
		{frameStatus, frameProtLimit, frameProtClass} = 96'h7007_8008_9009_A00A_B00B_C00C;
		{frameInitMask, frameMinorMask} = 128'hA1A1_0001_B2B2_0002_C3C3_0003_D4D4_0004;
		{frameMajorMask, frameActiveMask} = 128'hE5E5_0005_F6F6_0006_0707_0007_1818_0008;
		{frameAverageCompleteMask, frameUpdateMask} = 128'h2929_0009_3A3A_000A_4B4B_000B_5C5C_000C;
		for (int i = 0; i < 9; i++)
			frameSequences[i*32+:32] = 32'h5EC0_0000 + 32'(i);
		rstn = 1'b0;
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		foreach (rows[r]) begin
			trigBase = trigCnt;
			run_frame(rows[r].ctrl, rows[r].chEn, rows[r].glob, rows[r].acq, rows[r].stall,
				rows[r].chEn != 12'h0, 1);
			check("row word count", {24'h0, rows[r].words}, expQ.size());
			check("trigger count", {31'h0, rows[r].trig}, trigCnt - trigBase);
		end
		reg_rd(`REG_DROP_COUNT, 32'h0);
		dropExp = 1'b1;
		run_frame(8'h04, 12'h003, 1'b0, 12'h000, 1'b0, 1'b1, 2);
		reg_rd(`REG_DROP_COUNT, 32'h1);
		reg_rd(`REG_STATUS, 32'h0000_0004);
		reg_wr(`REG_SELECT, 32'h0028_0402);
		reg_rd(`REG_SELECT, 32'h0028_0402);
		reg_rd(8'h40, 32'h0);
		for (int m = 0; m < 3; m++)
			run_frame(8'h05 | 8'(m << 4), 12'h001, m == 2, 12'h000, 1'b0, m != 0, 1);
		tally_and_finish();
	end
endmodule // test_timing_frame_dma_message_formatter

// ---- sim/timing_frame_dma_message_formatter_monitor.sv ----
// Port checker for the timing message formatter, bound to its top module
`timescale 1ns/1ps

module timing_frame_dma_message_formatter_monitor #(
	parameter int NCH = 12
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic dmaReady,
	input wire logic dmaValid,
	input wire logic [31:0] dmaData,
	input wire logic dmaLast,
	input wire logic triggerOut
);
	logic [4:0] idx;
	logic [3:0] typ;
	wire take = dmaValid && dmaReady;
	wire isHdr = dmaValid && (idx == 5'd0);
	wire [3:0] curTyp = (idx == 5'd0) ? dmaData[19:16] : typ;
	wire [4:0] msgLen = curTyp == 4'h0 ? 5'd23 : (curTyp == 4'hF ? 5'd1 : 5'd11);

	// Word position inside the current message
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			idx <= 5'd0;
			typ <= 4'hF;
		end else if (take) begin
			idx <= (idx + 5'd1 == msgLen) ? 5'd0 : idx + 5'd1;
			typ <= curTyp;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	chk_hdr_own: assert property (isHdr |-> dmaData[31] && dmaData[29:24] == 6'h00 &&
		dmaData[21:20] == 2'h0) else $error("header ownership or unused bits wrong");
	chk_drop_pair: assert property (isHdr |-> dmaData[30] == dmaData[23])
		else $error("drop flags disagree");
	chk_type_code: assert property (isHdr |-> dmaData[19:16] inside {4'h0, 4'h1, 4'h2, 4'hF})
		else $error("unknown message type");
	chk_pulse_chan: assert property (isHdr && dmaData[19:16] == 4'h2 |-> dmaData[15:0] < NCH)
		else $error("pulse message channel out of range");
	chk_event_len: assert property (dmaValid && idx == 5'd1 && typ == 4'h0 |-> dmaData == 32'd21)
		else $error("event length word wrong");
	chk_rate_unused: assert property (dmaValid && idx == 5'd6 && typ == 4'h0 |-> dmaData[9:7] == 3'h0)
		else $error("unused rate bits set");
	chk_last_end: assert property (dmaValid |-> dmaLast == (isHdr && dmaData[19:16] == 4'hF))
		else $error("last flag not on end marker");
	chk_group_order: assert property (take && isHdr && dmaData[19:16] != 4'hF && typ != 4'hF
		|-> dmaData[19:16] >= typ) else $error("message order broken");
	chk_stall_hold: assert property (dmaValid && !dmaReady |=> dmaValid && $stable(dmaData)
		&& $stable(dmaLast)) else $error("word changed under stall");
	chk_trig_pulse: assert property (triggerOut |=> !triggerOut)
		else $error("trigger longer than one cycle");
endmodule // timing_frame_dma_message_formatter_monitor

bind timing_frame_dma_message_formatter timing_frame_dma_message_formatter_monitor #(.NCH(NCH))
	monitor_inst (.core_clk, .rstn, .dmaReady, .dmaValid, .dmaData, .dmaLast, .triggerOut);
